// [include/etx_pkg.sv]
// Shared constants and types for the Ethernet transmit framer block
package etx_pkg;
  // Register map, byte addresses on the Wishbone bus
  localparam int ETX_ADR_W = 4;
  localparam logic [3:0] ETX_REG_PHY_CFG = 4'h0;
  localparam logic [3:0] ETX_REG_STATUS = 4'h4;
  localparam logic [3:0] ETX_REG_TX_LAT = 4'h8;
  localparam logic [3:0] ETX_REG_TX_FRAMES = 4'hC;
  // Soft reset bits of the configuration word
  localparam int ETX_CFG_TX_RST = 0;
  localparam int ETX_CFG_RX_RST = 1;
  localparam int ETX_CFG_SYS_RST = 2;
  localparam logic [2:0] ETX_CFG_RESET = 3'h0;
  // Status bits
  localparam int ETX_ST_TX_STABLE = 0;
  localparam int ETX_ST_RX_READY = 1;
  localparam int ETX_ST_TX_BUSY = 2;
  // Latency register, 16.16 ns, widened to 48.16 when used
  localparam logic [31:0] ETX_TX_LAT_RESET = 32'h0000_0000;
  // 48.16 time format
  localparam int ETX_TOD_W = 64;
  localparam int ETX_TOD_FRAC_W = 16;
  localparam int ETX_TOD_NS_W = 48;
  // Line coding, lane 0 goes out first
  localparam logic [63:0] ETX_PRE_WORD = 64'hD555_5555_5555_55FB;
  localparam logic [7:0] ETX_PRE_CTRL = 8'h01;
  localparam logic [7:0] ETX_CTL_TERM = 8'hFD;
  localparam logic [7:0] ETX_CTL_IDLE = 8'h07;
  localparam logic [7:0] ETX_CTL_ERR = 8'hFE;
  localparam logic [15:0] ETX_MIN_BODY = 16'd60;
  localparam logic [15:0] ETX_FCS_BYTES = 16'd4;
  localparam int ETX_GAP_WORDS = 2;
  localparam logic [31:0] ETX_CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] ETX_CRC_POLY = 32'hEDB8_8320;
  typedef enum logic [2:0] {
    ETX_IDLE = 3'b000,
    ETX_PRE = 3'b001,
    ETX_BODY = 3'b010,
    ETX_TAIL = 3'b011,
    ETX_GAP = 3'b100
  } etx_state_e;
endpackage

// [hw/etx_crc32.sv]
// Byte-masked reflected CRC-32 over one 8-lane word
`timescale 1ns/1ns
module etx_crc32 #(
  parameter int LANES = 8
) (
  input wire logic [31:0] crc_i,
  input wire logic [8*LANES-1:0] data_i,
  input wire logic [LANES-1:0] en_i,
  output logic [31:0] crc_o
);
  import etx_pkg::*;
  always_comb begin
    logic [31:0] c;
    c = crc_i;
    for (int k = 0; k < LANES; k++) begin
      if (en_i[k]) begin
        c = c ^ {24'h000000, data_i[8*k +: 8]};
        for (int b = 0; b < 8; b++) begin
          c = c[0] ? ((c >> 1) ^ ETX_CRC_POLY) : (c >> 1);
        end
      end
    end
    crc_o = c;
  end
endmodule // etx_crc32

// [hw/etx_tod_add.sv]
// Adder for 48.16 nanosecond time values
`timescale 1ns/1ns
module etx_tod_add (
  input wire logic [etx_pkg::ETX_TOD_W-1:0] a_i,
  input wire logic [etx_pkg::ETX_TOD_W-1:0] b_i,
  output logic [etx_pkg::ETX_TOD_W-1:0] sum_o
);
  import etx_pkg::*;
  logic [ETX_TOD_FRAC_W:0] frac_sum;
  logic [ETX_TOD_NS_W-1:0] ns_sum;
  // Fraction wraps past all ones and carries one ns upward
  assign frac_sum = {1'b0, a_i[ETX_TOD_FRAC_W-1:0]} + {1'b0, b_i[ETX_TOD_FRAC_W-1:0]};
  assign ns_sum = a_i[ETX_TOD_W-1:ETX_TOD_FRAC_W] + b_i[ETX_TOD_W-1:ETX_TOD_FRAC_W]
    + {{(ETX_TOD_NS_W-1){1'b0}}, frac_sum[ETX_TOD_FRAC_W]};
  assign sum_o = {ns_sum, frac_sum[ETX_TOD_FRAC_W-1:0]};
endmodule // etx_tod_add

// [hw/etx_tx_mac.sv]
// Transmit framer, client byte order, soft resets and Wishbone registers
// Functional notes
// R1: Time values: 48-bit ns over 16-bit fraction
// R2: Fraction carries into ns past all ones
// R3: Timestamps in and out use 48.16 format
// R4: Software retunes period and delay per speed; this block has no period setting, only the delay through the latency register
// R5: Reverse bits, add gap, delimiters, zero pad
// R6: Compute frame check sequence and append it
// R7: Started packet runs out with no idles
// R8: Between packets ignore data, send idles
// R9: Line frame: preamble first, check sequence last
// R10: Client presents most significant bytes first
// R11: Receive side delivers most significant bytes first
// R12: Address bit 40 group, bit 41 local
// R13: First octet low bit goes out first
// R14: Soft resets stay until software clears them
// R15: Hard reset restores every register value
// R16: Each soft reset is one configuration bit
// R17: Transmit soft reset drops lanes stable
// R18: Receive soft reset drops coding ready
// R19: System reset drops both, keeps registers
// R20: Client never sends packets under nine bytes
// R21: Zero pad frames under sixty-four bytes
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module etx_tx_mac (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Wishbone slave
  input wire logic [etx_pkg::ETX_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit client stream, ready latency zero
  input wire logic [63:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_sop_i,
  input wire logic tx_eop_i,
  input wire logic [2:0] tx_empty_i,
  input wire logic tx_error_i,
  output logic tx_ready_o,
  // Time of day and egress timestamp
  input wire logic [etx_pkg::ETX_TOD_W-1:0] tod_i,
  output logic [etx_pkg::ETX_TOD_W-1:0] tx_ts_o,
  output logic tx_ts_valid_o,
  // Line side, 8 lanes with control flags
  output logic [63:0] line_txd_o,
  output logic [7:0] line_txc_o,
  // Receive words from the decoder and to the client
  input wire logic [63:0] line_rxd_i,
  input wire logic line_rx_valid_i,
  output logic [63:0] rx_data_o,
  output logic rx_valid_o,
  // Lock inputs and readiness outputs
  input wire logic tx_lock_i,
  input wire logic rx_lock_i,
  output logic tx_lanes_stable_o,
  output logic rx_pcs_ready_o
);
  import etx_pkg::*;

  function automatic logic [63:0] lane_swap(input logic [63:0] w);
    logic [63:0] r;
    r = 64'h0;
    for (int k = 0; k < 8; k++) begin
      r[8*k +: 8] = w[63-8*k -: 8];
    end
    return r;
  endfunction

  // ---------------- Registers ----------------
  logic [2:0] phy_cfg_r, phy_cfg_nxt;
  logic [31:0] lat_r, lat_nxt;
  logic [31:0] frames_r, frames_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic wb_req, wb_wr;
  logic tx_rst, rx_rst;
  logic frame_done;
  logic [31:0] status_w;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  // Transmit logic is held while either soft reset that covers it is set
  assign tx_rst = sys_rst_i || phy_cfg_r[ETX_CFG_TX_RST] || phy_cfg_r[ETX_CFG_SYS_RST]; // R16
  assign rx_rst = sys_rst_i || phy_cfg_r[ETX_CFG_RX_RST] || phy_cfg_r[ETX_CFG_SYS_RST]; // R16

  always_comb begin
    phy_cfg_nxt = phy_cfg_r;
    lat_nxt = lat_r;
    frames_nxt = frames_r + {31'h0, frame_done};
    ack_nxt = wb_req;
    rdat_nxt = rdat_r;
    status_w = 32'h0;
    status_w[ETX_ST_TX_STABLE] = tx_lanes_stable_o;
    status_w[ETX_ST_RX_READY] = rx_pcs_ready_o;
    status_w[ETX_ST_TX_BUSY] = tx_ready_o == 1'b0;
    if (wb_wr) begin
      case (wb_adr_i)
        // Bits only change on a write, never by themselves
        ETX_REG_PHY_CFG: if (wb_sel_i[0]) phy_cfg_nxt = wb_dat_i[2:0]; // R14
        ETX_REG_TX_LAT: begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) lat_nxt[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
        default: ;
      endcase
    end
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        ETX_REG_PHY_CFG: rdat_nxt = {29'h0, phy_cfg_r};
        ETX_REG_STATUS: rdat_nxt = status_w;
        ETX_REG_TX_LAT: rdat_nxt = lat_r;
        ETX_REG_TX_FRAMES: rdat_nxt = frames_r;
        default: rdat_nxt = 32'h0;
      endcase
    end
  end

  // Only the hard reset touches the registers; soft resets leave them alone
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin // R15 R19
      phy_cfg_r <= ETX_CFG_RESET;
      lat_r <= ETX_TX_LAT_RESET;
      frames_r <= 32'h0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      phy_cfg_r <= phy_cfg_nxt;
      lat_r <= lat_nxt;
      frames_r <= frames_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ---------------- Readiness and receive order ----------------
  always_ff @(posedge mclk_i) begin
    if (tx_rst) tx_lanes_stable_o <= 1'b0; // R17 R19
    else tx_lanes_stable_o <= tx_lock_i;
    if (rx_rst) begin // R18 R19
      rx_pcs_ready_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= 64'h0;
    end else begin
      rx_pcs_ready_o <= rx_lock_i;
      rx_valid_o <= line_rx_valid_i && rx_pcs_ready_o;
      rx_data_o <= lane_swap(line_rxd_i); // R11
    end
  end

  // ---------------- Transmit framer ----------------
  etx_state_e st_r, st_nxt;
  logic [63:0] hold_r, hold_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] dend_r, dend_nxt;
  logic err_r, err_nxt;
  logic [1:0] gap_r, gap_nxt;
  logic [31:0] crc_r, crc_nxt, crc_out;
  logic [63:0] txd_nxt;
  logic [7:0] txc_nxt;
  logic [63:0] crc_dat;
  logic [7:0] crc_en;
  logic [15:0] pend;
  logic [31:0] fcs;
  logic [63:0] ts_sum;
  logic accept_sop;

  // Client byte 0 (bits 63:56, first address octet) lands on lane 0; the
  // line then sends each lane low bit first, so DA bit 40 leads the frame
  logic [63:0] hold_sw;
  assign hold_sw = lane_swap(hold_r); // R10 R12 R13 R5
  assign pend = (dend_r < ETX_MIN_BODY) ? ETX_MIN_BODY : dend_r; // R21
  assign fcs = ~crc_out;
  // A packet with start and end in one word is silently dropped
  assign accept_sop = tx_valid_i && tx_sop_i && !tx_eop_i; // R20
  assign tx_ready_o = !tx_rst && (st_r == ETX_IDLE || st_r == ETX_BODY);

  // Bytes that feed the check sequence this cycle: data then zero padding
  always_comb begin
    logic [15:0] fidx;
    fidx = 16'h0;
    crc_dat = 64'h0;
    crc_en = 8'h00;
    if (st_r == ETX_BODY) begin
      crc_dat = hold_sw;
      crc_en = 8'hFF;
    end else if (st_r == ETX_TAIL) begin
      for (int k = 0; k < 8; k++) begin
        fidx = cnt_r + 16'(k);
        if (fidx < dend_r) crc_dat[8*k +: 8] = hold_sw[8*k +: 8];
        crc_en[k] = fidx < pend; // R6 R21
      end
    end
  end

  etx_crc32 #(
    .LANES(8)
  ) u_crc (
    .crc_i(crc_r),
    .data_i(crc_dat),
    .en_i(crc_en),
    .crc_o(crc_out)
  );

  etx_tod_add u_ts (
    .a_i(tod_i),
    .b_i({16'h0, lat_r, 16'h0} >> 16), // R1 R3
    .sum_o(ts_sum)
  );

  always_comb begin
    logic [15:0] fidx;
    logic [15:0] fpos;
    fidx = 16'h0;
    fpos = 16'h0;
    st_nxt = st_r;
    hold_nxt = hold_r;
    cnt_nxt = cnt_r;
    dend_nxt = dend_r;
    err_nxt = err_r;
    gap_nxt = gap_r;
    crc_nxt = crc_out;
    txd_nxt = {8{ETX_CTL_IDLE}};
    txc_nxt = 8'hFF;
    frame_done = 1'b0;
    case (st_r)
      ETX_IDLE: begin
        // Data between packets is not looked at
        if (accept_sop) begin // R8
          hold_nxt = tx_data_i;
          cnt_nxt = 16'h0;
          err_nxt = 1'b0;
          st_nxt = ETX_PRE;
        end
      end
      ETX_PRE: begin
        txd_nxt = ETX_PRE_WORD; // R9 R5
        txc_nxt = ETX_PRE_CTRL;
        crc_nxt = ETX_CRC_INIT;
        st_nxt = ETX_BODY;
      end
      ETX_BODY: begin
        // Client must keep valid high; a gap here would corrupt the frame
        txd_nxt = hold_sw; // R7
        txc_nxt = 8'h00;
        cnt_nxt = cnt_r + 16'd8;
        hold_nxt = tx_data_i;
        if (tx_valid_i && tx_eop_i) begin
          dend_nxt = cnt_r + 16'd16 - {13'h0, tx_empty_i};
          err_nxt = tx_error_i;
          st_nxt = ETX_TAIL;
        end
      end
      ETX_TAIL: begin
        txc_nxt = 8'h00;
        for (int k = 0; k < 8; k++) begin
          fidx = cnt_r + 16'(k);
          if (fidx < dend_r) begin
            txd_nxt[8*k +: 8] = hold_sw[8*k +: 8];
          end else if (fidx < pend) begin
            txd_nxt[8*k +: 8] = 8'h00; // R5 R21
          end else if (fidx < pend + ETX_FCS_BYTES) begin
            fpos = fidx - pend;
            txd_nxt[8*k +: 8] = fcs[8*fpos[1:0] +: 8]; // R6 R9
            if (err_r && fpos == 16'h0) begin
              txd_nxt[8*k +: 8] = ETX_CTL_ERR;
              txc_nxt[k] = 1'b1;
            end
          end else if (fidx == pend + ETX_FCS_BYTES) begin
            txd_nxt[8*k +: 8] = ETX_CTL_TERM; // R5
            txc_nxt[k] = 1'b1;
          end else begin
            txd_nxt[8*k +: 8] = ETX_CTL_IDLE;
            txc_nxt[k] = 1'b1;
          end
        end
        cnt_nxt = cnt_r + 16'd8;
        if (cnt_r + 16'd8 > pend + ETX_FCS_BYTES) begin
          gap_nxt = 2'(ETX_GAP_WORDS - 1);
          frame_done = 1'b1;
          st_nxt = ETX_GAP;
        end
      end
      ETX_GAP: begin
        // Whole idle words after the terminate keep the gap at least twelve
        gap_nxt = gap_r - 2'd1; // R5
        if (gap_r == 2'd0) st_nxt = ETX_IDLE;
      end
      default: st_nxt = ETX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (tx_rst) begin
      st_r <= ETX_IDLE;
      hold_r <= 64'h0;
      cnt_r <= 16'h0;
      dend_r <= 16'h0;
      err_r <= 1'b0;
      gap_r <= 2'd0;
      crc_r <= ETX_CRC_INIT;
      line_txd_o <= {8{ETX_CTL_IDLE}};
      line_txc_o <= 8'hFF;
      tx_ts_o <= 64'h0;
      tx_ts_valid_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hold_r <= hold_nxt;
      cnt_r <= cnt_nxt;
      dend_r <= dend_nxt;
      err_r <= err_nxt;
      gap_r <= gap_nxt;
      crc_r <= crc_nxt;
      line_txd_o <= txd_nxt;
      line_txc_o <= txc_nxt;
      tx_ts_valid_o <= st_r == ETX_IDLE && accept_sop;
      if (st_r == ETX_IDLE && accept_sop) tx_ts_o <= ts_sum; // R2 R3
    end
  end

  // ---------------- Checks ----------------
  AST_PREAMBLE_LEADS: assert property (@(posedge mclk_i) disable iff (tx_rst) // R9
    st_r == ETX_IDLE && accept_sop |-> ##2 line_txd_o == ETX_PRE_WORD
      && line_txc_o == ETX_PRE_CTRL)
    else $error("preamble word not sent two cycles after start");
  AST_IDLE_BETWEEN: assert property (@(posedge mclk_i) disable iff (tx_rst) // R8
    st_r == ETX_IDLE && !accept_sop |=> st_r == ETX_IDLE ##1 line_txc_o == 8'hFF)
    else $error("line not idle between packets");
  AST_NO_IDLE_IN_BODY: assert property (@(posedge mclk_i) disable iff (tx_rst) // R7
    st_r == ETX_BODY |=> line_txc_o == 8'h00)
    else $error("control character inside packet body");
  AST_SOFT_STICKY: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R14
    !wb_wr || wb_adr_i != ETX_REG_PHY_CFG |=> phy_cfg_r == $past(phy_cfg_r))
    else $error("soft reset bits changed without a write");
  AST_HARD_RESET: assert property (@(posedge mclk_i) // R15
    sys_rst_i |=> phy_cfg_r == ETX_CFG_RESET && lat_r == ETX_TX_LAT_RESET
      && frames_r == 32'h0)
    else $error("hard reset left a register set");
  AST_TX_STABLE_DROP: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R17
    phy_cfg_r[ETX_CFG_TX_RST] || phy_cfg_r[ETX_CFG_SYS_RST] |=> !tx_lanes_stable_o
      && st_r == ETX_IDLE)
    else $error("transmit soft reset did not drop lanes stable");
  AST_RX_READY_DROP: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R18
    phy_cfg_r[ETX_CFG_RX_RST] || phy_cfg_r[ETX_CFG_SYS_RST] |=> !rx_pcs_ready_o)
    else $error("receive soft reset did not drop coding ready");
  AST_SYS_KEEPS_CSR: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R19
    phy_cfg_r[ETX_CFG_SYS_RST] && !wb_wr |=> lat_r == $past(lat_r))
    else $error("system soft reset disturbed a register");
  AST_TS_48_16: assert property (@(posedge mclk_i) disable iff (tx_rst) // R1
    tx_ts_valid_o |-> tx_ts_o == $past(tod_i) + {32'h0, $past(lat_r)})
    else $error("timestamp not entry time plus latency in 48.16");
  AST_RX_MSB_FIRST: assert property (@(posedge mclk_i) disable iff (rx_rst) // R11
    rx_valid_o |-> rx_data_o[63:56] == $past(line_rxd_i[7:0]))
    else $error("receive lane 0 not on the top client byte");
  AST_MIN_FRAME: assert property (@(posedge mclk_i) disable iff (tx_rst) // R21
    st_r == ETX_TAIL && st_nxt == ETX_GAP |-> cnt_r + 16'd8 > ETX_MIN_BODY)
    else $error("frame ended below minimum length");
endmodule // etx_tx_mac

// [dv/etx_client_src.sv]
// Client-side packet source feeding the transmit stream
`timescale 1ns/1ns
module etx_client_src (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [15:0] len_i,
  input wire logic err_i,
  input wire logic tx_ready_i,
  output logic [63:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_sop_o,
  output logic tx_eop_o,
  output logic [2:0] tx_empty_o,
  output logic tx_error_o,
  output logic busy_o
);
  logic [15:0] pos_r;
  logic [15:0] len_r;
  logic err_r;
  logic [15:0] np;
  logic [15:0] ne;
  function automatic logic [7:0] pbyte(input int i);
    logic [47:0] dst;
    dst = 48'hACDE_4800_0080;
    if (i < 6) return dst[47-8*i -: 8];
    return i[7:0];
  endfunction
  function automatic logic [63:0] word(input int p, input int n);
    for (int k = 0; k < 8; k++) word[63-8*k -: 8] = (p + k < n) ? pbyte(p + k) : 8'h00;
  endfunction
  assign np = pos_r + 16'h0008;
  assign ne = np + 16'h0008;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_valid_o <= 1'b0;
      tx_sop_o <= 1'b0;
      tx_eop_o <= 1'b0;
      tx_empty_o <= 3'h0;
      tx_error_o <= 1'b0;
      tx_data_o <= 64'h0;
      busy_o <= 1'b0;
    end else if (start_i && !busy_o) begin
      // Callers never ask for fewer than nine bytes, so the first word is never the last
      pos_r <= 16'h0000;
      len_r <= len_i;
      err_r <= err_i;
      busy_o <= 1'b1;
      tx_valid_o <= 1'b1;
      tx_sop_o <= 1'b1;
      tx_data_o <= word(0, len_i);
    end else if (tx_valid_o && tx_ready_i) begin
      tx_sop_o <= 1'b0;
      if (tx_eop_o) begin
        tx_valid_o <= 1'b0;
        tx_eop_o <= 1'b0;
        tx_error_o <= 1'b0;
        busy_o <= 1'b0;
        tx_data_o <= ~tx_data_o;
      end else begin
        pos_r <= np;
        tx_data_o <= word(np, len_r);
        tx_eop_o <= (ne >= len_r);
        tx_empty_o <= 3'(ne - len_r);
        tx_error_o <= err_r && (ne >= len_r);
      end
    end else if (!tx_valid_o) begin
      // Released data keeps changing so idle input can never pass for a frame
      tx_data_o <= ~tx_data_o;
    end
  end
endmodule // etx_client_src

// [dv/tb.sv]
// Self-checking bench for the transmit framer block
`timescale 1ns/1ns
module tb;
  import etx_pkg::*;
  logic mclk_i, sys_rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, tx_valid_i, tx_sop_i;
  logic tx_eop_i, tx_error_i, tx_ready_o, tx_ts_valid_o, line_rx_valid_i, rx_valid_o;
  logic tx_lock_i, rx_lock_i, tx_lanes_stable_o, rx_pcs_ready_o, start, perr, busy;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [63:0] tx_data_i, tod_i, tx_ts_o, line_txd_o, line_rxd_i, rx_data_o, ts_seen;
  logic [7:0] line_txc_o;
  logic [2:0] tx_empty_i;
  logic [15:0] plen;
  logic [7:0] dq[$], last_q[$], eq[$];
  logic in_frame = 1'b0;
  int num_errors = 0, total_checks = 0, cycles = 0, n_eof = 0, n_bad = 0, idle_w = 0, ts_cnt = 0;
  etx_tx_mac i_dut (.mclk_i, .sys_rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_data_i, .tx_valid_i, .tx_sop_i, .tx_eop_i, .tx_empty_i,
    .tx_error_i, .tx_ready_o, .tod_i, .tx_ts_o, .tx_ts_valid_o, .line_txd_o, .line_txc_o,
    .line_rxd_i, .line_rx_valid_i, .rx_data_o, .rx_valid_o, .tx_lock_i, .rx_lock_i,
    .tx_lanes_stable_o, .rx_pcs_ready_o);
  etx_client_src i_src (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .start_i(start), .len_i(plen),
    .err_i(perr), .tx_ready_i(tx_ready_o), .tx_data_o(tx_data_i), .tx_valid_o(tx_valid_i),
    .tx_sop_o(tx_sop_i), .tx_eop_o(tx_eop_i), .tx_empty_o(tx_empty_i),
    .tx_error_o(tx_error_i), .busy_o(busy));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string m);
    wb(1'b0, a, 32'h0, 4'hF);
    chk({32'h0, rd}, {32'h0, exp}, m);
  endtask
  // Line monitor: collects data bytes of each frame, watches gaps and stamps
  always @(posedge mclk_i) begin
    cycles++;
    if (tx_ts_valid_o === 1'b1) begin
      ts_seen = tx_ts_o;
      ts_cnt++;
    end
    if (line_txc_o === 8'hFF && line_txd_o === {8{ETX_CTL_IDLE}}) begin
      if (in_frame) chk(64'h1, 64'h0, "idle in frame");
      idle_w++;
    end else begin
      for (int k = 0; k < 8; k++) begin
        if (line_txc_o[k] !== 1'b1) begin
          if (in_frame) dq.push_back(line_txd_o[8*k +: 8]);
        end else if (line_txd_o[8*k +: 8] === ETX_PRE_WORD[7:0]) begin
          chk(64'(idle_w >= ETX_GAP_WORDS), 64'h1, "gap");
          in_frame = 1'b1;
          dq.delete();
        end else if (line_txd_o[8*k +: 8] === ETX_CTL_TERM) begin
          in_frame = 1'b0;
          last_q = dq;
          n_eof++;
        end else if (line_txd_o[8*k +: 8] === ETX_CTL_ERR) n_bad++;
      end
      idle_w = 0;
    end
    if (cycles == 20000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      conclude();
    end
  end
  task automatic send(input int len, input logic err);
    int e0, t0, b0;
    logic [31:0] crc;
    logic [7:0] b;
    e0 = n_eof;
    t0 = ts_cnt;
    b0 = n_bad;
    @(posedge mclk_i);
    start <= 1'b1;
    plen <= 16'(len);
    perr <= err;
    @(posedge mclk_i);
    start <= 1'b0;
    do @(posedge mclk_i); while (busy === 1'b1);
    while (n_eof == e0) @(posedge mclk_i);
    eq.delete();
    for (int i = 0; i < 7; i++) eq.push_back(i < 6 ? 8'h55 : 8'hD5);
    crc = ETX_CRC_INIT;
    for (int i = 0; i < 60 || i < len; i++) begin
      b = (i < len) ? i_src.pbyte(i) : 8'h00;
      eq.push_back(b);
      crc = crc ^ {24'h0, b};
      for (int j = 0; j < 8; j++) crc = crc[0] ? (crc >> 1) ^ ETX_CRC_POLY : crc >> 1;
    end
    for (int i = 0; i < 4; i++) eq.push_back(~crc[8*i +: 8]);
    // A bad frame carries the error code in place of the first check byte
    if (err) eq.delete(eq.size() - 4);
    chk(64'(last_q.size()), 64'(eq.size()), "frame size");
    foreach (eq[i]) if (i < last_q.size()) chk({56'h0, last_q[i]}, {56'h0, eq[i]}, "byte");
    chk(64'(n_bad - b0), 64'(err), "error mark");
    chk(64'(ts_cnt - t0), 64'h1, "stamp count");
    chk(ts_seen, {48'h4, 16'h0010}, "stamp");
    $display("test frame of %0d bytes done", len);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    {sys_rst_i, tx_lock_i, rx_lock_i} = 3'b111;
    {wb_we_i, wb_cyc_i, wb_stb_i, line_rx_valid_i, start, perr} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, plen, line_rxd_i} = '0;
    tod_i = {48'h1, 16'hFFF0};
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rchk(ETX_REG_PHY_CFG, 32'h0, "cfg reset");
    rchk(ETX_REG_TX_LAT, ETX_TX_LAT_RESET, "lat reset");
    rchk(4'h2, 32'h0, "unmapped");
    wb(1'b1, ETX_REG_TX_LAT, 32'hAAAA_0020, 4'h3);
    rchk(ETX_REG_TX_LAT, 32'h0000_0020, "lat bytes");
    wb(1'b1, ETX_REG_TX_LAT, 32'h0002_0020, 4'hF);
    rchk(ETX_REG_STATUS, 32'h3, "status up");
    $display("test registers done");
    for (int b = 0; b < 3; b++) begin
      wb(1'b1, ETX_REG_PHY_CFG, 32'h1 << b, 4'h1);
      repeat (8) @(posedge mclk_i);
      chk({62'h0, tx_lanes_stable_o, rx_pcs_ready_o}, {62'h0, b == 1, b == 0}, "soft");
      rchk(ETX_REG_PHY_CFG, 32'h1 << b, "soft bit holds");
      rchk(ETX_REG_TX_LAT, 32'h0002_0020, "kept");
      wb(1'b1, ETX_REG_PHY_CFG, 32'h0, 4'h1);
      repeat (8) @(posedge mclk_i);
      chk({62'h0, tx_lanes_stable_o, rx_pcs_ready_o}, 64'h3, "release");
    end
    $display("test soft resets done");
    send(20, 1'b0);
    send(9, 1'b1);
    send(60, 1'b0);
    @(posedge mclk_i);
    line_rxd_i <= 64'h0706_0504_0302_0100;
    line_rx_valid_i <= 1'b1;
    @(posedge mclk_i);
    line_rx_valid_i <= 1'b0;
    @(negedge mclk_i);
    chk(rx_data_o, 64'h0001_0203_0405_0607, "rx order");
    chk({63'h0, rx_valid_o}, 64'h1, "rx valid");
    $display("test receive order done");
    rchk(ETX_REG_TX_FRAMES, 32'h3, "frames sent");
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rchk(ETX_REG_TX_LAT, ETX_TX_LAT_RESET, "hard lat");
    rchk(ETX_REG_TX_FRAMES, 32'h0, "hard frames");
    $display("test hard reset done");
    conclude();
  end
endmodule // tb
